// ### include/ccdseq_regs.svh
`ifndef CCDSEQ_REGS_SVH
`define CCDSEQ_REGS_SVH
// Clock rate in MHz
`define CCDSEQ_CLK_MHZ 100
// Timing figures in ns, as printed for the sequencer
`define CCDSEQ_ROW_EXIT_NS 1000
`define CCDSEQ_ROW_PASS_NS 1000
`define CCDSEQ_ROW_GATE_NS 1000
`define CCDSEQ_LINE_LOAD_NS 1000
`define CCDSEQ_DUMP_SETTLE_NS 1000
`define CCDSEQ_FLUSH_PULSE_NS 1000
`define CCDSEQ_HALF_PIX_NS 50
// Least times round up to whole cycles
`define CCDSEQ_CYC(ns) (((ns) * `CCDSEQ_CLK_MHZ + 999) / 1000)
`define CCDSEQ_ROW_EXIT_CYC `CCDSEQ_CYC(`CCDSEQ_ROW_EXIT_NS)
`define CCDSEQ_ROW_PASS_CYC `CCDSEQ_CYC(`CCDSEQ_ROW_PASS_NS)
`define CCDSEQ_ROW_GATE_CYC `CCDSEQ_CYC(`CCDSEQ_ROW_GATE_NS)
`define CCDSEQ_LINE_LOAD_CYC `CCDSEQ_CYC(`CCDSEQ_LINE_LOAD_NS)
`define CCDSEQ_DUMP_SETTLE_CYC `CCDSEQ_CYC(`CCDSEQ_DUMP_SETTLE_NS)
`define CCDSEQ_FLUSH_PULSE_CYC `CCDSEQ_CYC(`CCDSEQ_FLUSH_PULSE_NS)
`define CCDSEQ_HALF_PIX_CYC `CCDSEQ_CYC(`CCDSEQ_HALF_PIX_NS)
// Counter width and pixel count per half line
`define CCDSEQ_CNT_W 16
`define CCDSEQ_PIX_PER_LINE 16'h1038
`endif

// ### include/ccdseq_pkg.sv
package ccdseq_pkg;
   // Pins driven onto the sensor
   typedef struct packed {
      logic vertical_phase_one;
      logic vertical_phase_two;
      logic horiz_a_first_phase;
      logic horiz_b_first_phase;
      logic horiz_last_phase;
      logic inter_register_gate;
      logic output_reset_gate_clock;
      logic global_flush_gate;
      logic row_dump_gate;
   } ccdseq_pins_s;
   // Which sensor outputs carry the current line
   typedef struct packed {
      logic left_a_output;
      logic right_a_output;
      logic left_b_output;
      logic right_b_output;
   } ccdseq_outsel_s;
   // Gray-coded in declaration order; ST_V2_FALL to ST_READ flips three bits
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_FL_V2 = 4'h1,
      ST_FL_PULSE = 4'h3,
      ST_FL_DROP = 4'h2,
      ST_INTEG = 4'h6,
      ST_V1_HI = 4'h7,
      ST_V2_HI = 4'h5,
      ST_V2_FALL = 4'h4,
      ST_XFER_A = 4'hc,
      ST_XFER_G = 4'hd,
      ST_READ = 4'hf,
      ST_DP_V2 = 4'he,
      ST_DP_PULSE = 4'ha,
      ST_DP_DROP = 4'hb,
      ST_DP_SETTLE = 4'h9,
      ST_DONE = 4'h8
   } ccdseq_state_e;
endpackage

// ### rtl/ccdseq_hclk.sv
`timescale 1ns/1ps
`include "ccdseq_regs.svh"
// Free-running pixel clock generator: reset gate always toggles, horizontal
// phases toggle only while reading so a line shifts out a packet per H fall.
module ccdseq_hclk
   import ccdseq_pkg::*;
(
   input wire logic mclk, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic run, // Shift horizontal register
   output logic h_phase, // Horizontal phase level
   output logic rg_clk, // Reset gate clock
   output logic pix_done // One cycle per falling horizontal edge
);
   logic [`CCDSEQ_CNT_W-1:0] cnt_ff, nxt_cnt;
   logic ph_ff, nxt_ph;
   logic hph_ff, nxt_hph;

   // Half-pixel tick; reset gate runs even when idle
   always_comb begin
      nxt_cnt = cnt_ff + 16'h0001;
      nxt_ph = ph_ff;
      nxt_hph = h_phase; // Last driven level, so the parked-high to low step counts too
      if (cnt_ff == `CCDSEQ_CNT_W'(`CCDSEQ_HALF_PIX_CYC - 1)) begin
         nxt_cnt = 16'h0000;
         nxt_ph = ~ph_ff;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= 16'h0000;
         ph_ff <= 1'b0;
         hph_ff <= 1'b1; // Parked level, so no false fall after reset
      end else begin
         cnt_ff <= nxt_cnt;
         ph_ff <= nxt_ph;
         hph_ff <= nxt_hph;
      end
   end

   assign h_phase = run ? ph_ff : 1'b1; // Parked high so a row can land
   assign rg_clk = ph_ff;
   // Every fall of the driven level is a packet, whatever phase the read starts in
   assign pix_done = hph_ff & ~h_phase;
endmodule

// ### rtl/ccdseq_top.sv
`timescale 1ns/1ps
`include "ccdseq_regs.svh"
module ccdseq_top
   import ccdseq_pkg::*;
(
   input wire logic mclk, // System clock, 100 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic frame_start, // Pulse: begin a frame
   input wire logic flush_en, // Do a global flush first
   input wire logic dual_parallel_split_mode, // 1 = four outputs, 0 = dual split
   input wire logic integ_end, // Pulse: end integration
   input wire logic [15:0] line_count, // Lines per frame
   input wire logic [15:0] dump_line, // Line index to dump instead of read, 0xffff none
   output ccdseq_pins_s pins, // Sensor clock pins
   output ccdseq_outsel_s out_sel, // Outputs carrying the line being read
   output logic busy, // Frame in progress
   output logic frame_done, // Pulse at frame end
   output logic line_start, // Pulse at start of a readout line
   output logic drain_done // Pulse when flush or dump completes
);
   ccdseq_state_e st_ff, nxt_st;
   logic [15:0] tmr_ff, nxt_tmr;
   logic [15:0] line_ff, nxt_line;
   logic [15:0] pix_ff, nxt_pix;
   logic dps_ff, nxt_dps;
   ccdseq_pins_s pins_ff, nxt_pins;
   ccdseq_outsel_s sel_ff, nxt_sel;
   logic busy_ff, nxt_busy, fdone_ff, nxt_fdone, lst_ff, nxt_lst, ddone_ff, nxt_ddone;
   logic h_run, h_phase, rg_clk, pix_done;
   logic tmr_zero;

   ccdseq_hclk u_hclk (
      .mclk(mclk),
      .rstn(rstn),
      .run(h_run),
      .h_phase(h_phase),
      .rg_clk(rg_clk),
      .pix_done(pix_done)
   );

   assign h_run = (st_ff == ST_READ);
   assign tmr_zero = (tmr_ff == 16'h0000);

   // Sequencer: timed states load a delay and wait for it to run out; IDLE, INTEG and READ wait on frame_start, integ_end and pix_done
   always_comb begin
      nxt_st = st_ff;
      nxt_tmr = tmr_zero ? tmr_ff : tmr_ff - 16'h0001;
      nxt_line = line_ff;
      nxt_pix = pix_ff;
      nxt_dps = dps_ff;
      nxt_busy = busy_ff;
      nxt_fdone = 1'b0;
      nxt_lst = 1'b0;
      nxt_ddone = 1'b0;
      unique case (st_ff)
         ST_IDLE: begin
            if (frame_start) begin
               nxt_dps = dual_parallel_split_mode;
               nxt_busy = 1'b1;
               nxt_line = 16'h0000;
               nxt_tmr = 16'(`CCDSEQ_ROW_EXIT_CYC);
               nxt_st = flush_en ? ST_FL_V2 : ST_INTEG;
            end
         end
         ST_FL_V2: if (tmr_zero) begin
            nxt_tmr = 16'(`CCDSEQ_FLUSH_PULSE_CYC);
            nxt_st = ST_FL_PULSE;
         end
         ST_FL_PULSE: if (tmr_zero) begin
            nxt_tmr = 16'(`CCDSEQ_ROW_EXIT_CYC);
            nxt_st = ST_FL_DROP;
         end
         ST_FL_DROP: if (tmr_zero) begin
            nxt_ddone = 1'b1;
            nxt_st = ST_INTEG;
         end
         ST_INTEG: if (integ_end) begin
            nxt_tmr = 16'(`CCDSEQ_ROW_EXIT_CYC);
            nxt_st = ST_V1_HI;
         end
         ST_V1_HI: if (tmr_zero) begin
            nxt_tmr = 16'(`CCDSEQ_ROW_EXIT_CYC);
            nxt_st = ST_V2_HI;
         end
         ST_V2_HI: if (tmr_zero) begin
            nxt_tmr = 16'(`CCDSEQ_LINE_LOAD_CYC);
            nxt_st = (line_ff == dump_line) ? ST_DP_PULSE : ST_V2_FALL;
         end
         ST_V2_FALL: if (tmr_zero) begin
            if (dps_ff && !line_ff[0]) begin
               nxt_tmr = 16'(`CCDSEQ_ROW_PASS_CYC);
               nxt_st = ST_XFER_A;
            end else begin
               nxt_pix = 16'h0000;
               nxt_lst = 1'b1;
               nxt_st = ST_READ;
            end
         end
         ST_XFER_A: if (tmr_zero) begin
            nxt_tmr = 16'(`CCDSEQ_ROW_GATE_CYC);
            nxt_st = ST_XFER_G;
         end
         ST_XFER_G: if (tmr_zero) begin
            // Even row now in B; load the odd row into A on the next V2 fall
            nxt_line = line_ff + 16'h0001;
            nxt_tmr = 16'(`CCDSEQ_ROW_EXIT_CYC);
            nxt_st = ST_V1_HI;
         end
         ST_READ: if (pix_done) begin
            nxt_pix = pix_ff + 16'h0001;
            if (pix_ff == `CCDSEQ_PIX_PER_LINE - 16'h0001) begin
               nxt_line = line_ff + 16'h0001;
               nxt_tmr = 16'(`CCDSEQ_ROW_EXIT_CYC);
               nxt_st = (line_ff + 16'h0001 >= line_count) ? ST_DONE : ST_V1_HI;
            end
         end
         ST_DP_PULSE: if (tmr_zero) begin
            nxt_tmr = 16'(`CCDSEQ_ROW_EXIT_CYC);
            nxt_st = ST_DP_DROP;
         end
         ST_DP_DROP: if (tmr_zero) begin
            nxt_tmr = 16'(`CCDSEQ_DUMP_SETTLE_CYC);
            nxt_st = ST_DP_SETTLE;
         end
         ST_DP_SETTLE: if (tmr_zero) begin
            nxt_ddone = 1'b1;
            nxt_line = line_ff + 16'h0001;
            nxt_tmr = 16'(`CCDSEQ_ROW_EXIT_CYC);
            nxt_st = (line_ff + 16'h0001 >= line_count) ? ST_DONE : ST_V1_HI;
         end
         ST_DONE: begin
            nxt_busy = 1'b0;
            nxt_fdone = 1'b1;
            nxt_st = ST_IDLE;
         end
         default: nxt_st = ST_IDLE; // Unused codes recover
      endcase
   end

   // Pin levels decoded from the next state so pins are registered
   always_comb begin
      nxt_pins = '0;
      nxt_pins.output_reset_gate_clock = rg_clk;
      nxt_pins.horiz_a_first_phase = 1'b1;
      nxt_sel = '0;
      unique case (nxt_st)
         ST_FL_V2, ST_FL_DROP, ST_DP_DROP: nxt_pins.vertical_phase_two = 1'b0;
         ST_FL_PULSE: begin
            nxt_pins.vertical_phase_two = 1'b1;
            nxt_pins.global_flush_gate = 1'b1;
         end
         ST_DP_PULSE: begin
            nxt_pins.vertical_phase_two = 1'b1;
            nxt_pins.row_dump_gate = 1'b1;
         end
         ST_V1_HI: nxt_pins.vertical_phase_one = 1'b1;
         ST_V2_HI: nxt_pins.vertical_phase_two = 1'b1;
         ST_XFER_G: nxt_pins.inter_register_gate = dps_ff;
         ST_READ: begin
            nxt_pins.horiz_a_first_phase = h_phase;
            nxt_pins.horiz_last_phase = h_phase;
            nxt_pins.horiz_b_first_phase = dps_ff & h_phase;
            if (dps_ff && line_ff[0]) begin
               nxt_sel.left_b_output = 1'b1;
               nxt_sel.right_b_output = 1'b1;
            end else begin
               nxt_sel.left_a_output = 1'b1;
               nxt_sel.right_a_output = 1'b1;
            end
         end
         default: nxt_pins.vertical_phase_one = 1'b0;
      endcase
      if (nxt_st == ST_FL_V2) begin
         nxt_pins.vertical_phase_two = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= ST_IDLE;
         tmr_ff <= 16'h0000;
         line_ff <= 16'h0000;
         pix_ff <= 16'h0000;
         dps_ff <= 1'b0;
         pins_ff <= '0;
         sel_ff <= '0;
         busy_ff <= 1'b0;
         fdone_ff <= 1'b0;
         lst_ff <= 1'b0;
         ddone_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         tmr_ff <= nxt_tmr;
         line_ff <= nxt_line;
         pix_ff <= nxt_pix;
         dps_ff <= nxt_dps;
         pins_ff <= nxt_pins;
         sel_ff <= nxt_sel;
         busy_ff <= nxt_busy;
         fdone_ff <= nxt_fdone;
         lst_ff <= nxt_lst;
         ddone_ff <= nxt_ddone;
      end
   end

   assign pins = pins_ff;
   assign out_sel = sel_ff;
   assign busy = busy_ff;
   assign frame_done = fdone_ff;
   assign line_start = lst_ff;
   assign drain_done = ddone_ff;
endmodule

// ### bench/ccdseq_chk.sv
`timescale 1ns/1ps
`include "ccdseq_regs.svh"
module ccdseq_chk
   import ccdseq_pkg::*;
(
   input wire logic mclk, // Clock
   input wire logic rstn, // Reset
   input wire logic frame_start, // Start
   input wire logic dual_parallel_split_mode, // Mode
   input wire ccdseq_pins_s pins, // Pins
   input wire logic busy, // Busy
   input wire logic frame_done, // End
   input wire logic drain_done // Drained
);
   localparam int SETTLE = `CCDSEQ_DUMP_SETTLE_CYC;
   logic mode_ff, nxt_mode, dump_ff, nxt_dump;
   logic [15:0] low_ff, nxt_low;
   // Mode as the design takes it; low_ff saturates so long idles cannot wrap
   always_comb begin
      nxt_mode = (frame_start && !busy) ? dual_parallel_split_mode : mode_ff;
      nxt_dump = pins.row_dump_gate | (dump_ff & !pins.global_flush_gate);
      nxt_low = pins.vertical_phase_two ? 16'h0000 : low_ff + {15'h0000, ~&low_ff};
   end
   // Helper registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mode_ff <= 1'b0;
         dump_ff <= 1'b0;
         low_ff <= 16'h0000;
      end else begin
         mode_ff <= nxt_mode;
         dump_ff <= nxt_dump;
         low_ff <= nxt_low;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_gate_mode: assert property (pins.inter_register_gate |-> mode_ff)
      else $error("transfer gate high in dual split");
   a_b_low: assert property (busy && !mode_ff |-> !pins.horiz_b_first_phase)
      else $error("B phase moves in dual split");
   a_flush_v2: assert property (pins.global_flush_gate |->
      pins.vertical_phase_two && !pins.vertical_phase_one)
      else $error("flush gate without V2 high");
   a_dump_v2: assert property (pins.row_dump_gate |-> pins.vertical_phase_two &&
      $past(pins.vertical_phase_two) && !pins.vertical_phase_one)
      else $error("dump gate without V2 high");
   a_rg_period: assert property ($rose(pins.output_reset_gate_clock) |=>
      pins.output_reset_gate_clock[*4] ##1 !pins.output_reset_gate_clock)
      else $error("reset gate clock off period");
   a_flush_done: assert property (drain_done && !dump_ff |->
      !pins.vertical_phase_two && low_ff != 16'h0000)
      else $error("flush done before V2 low");
   a_dump_settle: assert property (drain_done && dump_ff |-> low_ff >= 16'(SETTLE - 1))
      else $error("dump done before settle time");
   a_frame_end: assert property (frame_done |-> !busy && $past(busy))
      else $error("busy wrong around frame end");
endmodule
bind ccdseq_top ccdseq_chk u_ccdseq_chk (.mclk(mclk), .rstn(rstn), .frame_start(frame_start),
   .dual_parallel_split_mode(dual_parallel_split_mode), .pins(pins), .busy(busy),
   .frame_done(frame_done), .drain_done(drain_done));

// ### bench/ccdseq_sensor_model.sv
`timescale 1ns/1ps
module ccdseq_sensor_model
   import ccdseq_pkg::*;
(
   input wire logic mclk, // Sampling clock
   input wire logic rstn, // Reset
   input wire ccdseq_pins_s pins, // Sensor pins
   output logic [31:0] pkts, // Packets sensed
   output logic [31:0] rows, // Rows into A
   output logic [31:0] flushes, // Array flushes
   output logic [31:0] dumps, // Dump row clears
   output logic [31:0] rgs, // Reset gate rises
   output logic [31:0] gap, // V2 fall to gate rise
   output logic b_loaded // Row in B
);
   ccdseq_pins_s p;
   logic [31:0] age;
   // Sensor has no clock; mclk only samples the pin edges it reacts to
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         p <= '0;
         {pkts, rows, flushes, dumps, rgs, gap, age} <= '0;
         b_loaded <= 1'b0;
      end else begin
         p <= pins;
         age <= (p.vertical_phase_two && !pins.vertical_phase_two) ? '0 : age + 1'h1;
         if (p.vertical_phase_two && !pins.vertical_phase_two && p.horiz_a_first_phase) begin
            rows <= rows + 1'h1;
         end
         if (p.horiz_last_phase && !pins.horiz_last_phase) begin
            pkts <= pkts + 1'h1;
         end
         if (!p.global_flush_gate && pins.global_flush_gate) begin
            flushes <= flushes + 1'h1;
         end
         if (!p.row_dump_gate && pins.row_dump_gate) begin
            dumps <= dumps + 1'h1;
         end
         if (!p.output_reset_gate_clock && pins.output_reset_gate_clock) begin
            rgs <= rgs + 1'h1;
         end
         if (!p.inter_register_gate && pins.inter_register_gate) begin
            gap <= age;
            b_loaded <= 1'b1;
         end
      end
   end
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
`include "ccdseq_regs.svh"
module tb import ccdseq_pkg::*;;
   logic mclk, rstn, frame_start, flush_en, dual_parallel_split_mode, integ_end, busy;
   logic frame_done, line_start, drain_done, b_loaded;
   logic [15:0] line_count, dump_line;
   ccdseq_pins_s pins;
   ccdseq_outsel_s out_sel;
   logic [31:0] pkts, rows, flushes, dumps, rgs, gap, p0, r0;
   int mismatches, compares;
   ccdseq_top u_ccdseq_top (.mclk(mclk), .rstn(rstn), .frame_start(frame_start),
      .flush_en(flush_en), .dual_parallel_split_mode(dual_parallel_split_mode),
      .integ_end(integ_end), .line_count(line_count), .dump_line(dump_line), .pins(pins),
      .out_sel(out_sel), .busy(busy), .frame_done(frame_done), .line_start(line_start),
      .drain_done(drain_done));
   ccdseq_sensor_model u_ccdseq_sensor_model (.mclk(mclk), .rstn(rstn), .pins(pins),
      .pkts(pkts), .rows(rows), .flushes(flushes), .dumps(dumps), .rgs(rgs), .gap(gap),
      .b_loaded(b_loaded));
   // 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      if (mismatches == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Bounded wait for drain (0), line start (1) or frame end (2), sampled off the edge
   task automatic await(input int sel, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (((sel == 0 ? drain_done : sel == 1 ? line_start : frame_done) !== 1'b1)
         && n < lim);
      if (n >= lim) check("pulse", 0, 1);
   endtask
   task automatic start(input logic fl, input logic dp, input logic [15:0] dl);
      @(posedge mclk);
      frame_start <= 1'b1;
      flush_en <= fl;
      dual_parallel_split_mode <= dp;
      dump_line <= dl;
      @(posedge mclk);
      frame_start <= 1'b0;
      repeat (20) @(posedge mclk);
   endtask
   task automatic end_integ();
      @(posedge mclk);
      integ_end <= 1'b1;
      @(posedge mclk);
      integ_end <= 1'b0;
   endtask
   // Flush then a dual split line; the second start lands while busy and must be dropped
   task automatic t_flush_ds();
      start(1'b1, 1'b0, 16'hffff);
      start(1'b1, 1'b0, 16'hffff);
      await(0, 1000);
      check("flushes", flushes, 32'h0000_0001);
      r0 = rows;
      p0 = pkts;
      repeat (20) @(negedge mclk);
      check("vclk", 32'({pins.vertical_phase_one, pins.vertical_phase_two}), 0);
      end_integ();
      await(1, 1000);
      repeat (3) @(negedge mclk);
      check("out_sel", 32'(out_sel), 32'h0000_000c);
      await(2, 50000);
      check("pkts", pkts - p0, 32'h0000_1038);
      check("rows", rows - r0, 32'h0000_0001);
      repeat (50) @(negedge mclk);
      check("busy", 32'(busy), 0);
      check("b_loaded", 32'(b_loaded), 0);
   endtask
   task automatic t_dps();
      r0 = rows;
      p0 = pkts;
      start(1'b0, 1'b1, 16'hffff);
      end_integ();
      await(1, 2000);
      repeat (3) @(negedge mclk);
      check("out_sel", 32'(out_sel), 32'h0000_0003);
      check("b_loaded", 32'(b_loaded), 1);
      check("gap", 32'(gap >= 32'(`CCDSEQ_ROW_PASS_CYC)), 1);
      check("rows", rows - r0, 32'h0000_0002);
      await(2, 60000);
      check("gate", 32'(pins.inter_register_gate), 0);
      check("pkts", pkts - p0, 32'h0000_1038);
   endtask
   // Dumped line is drained, not read; reset gate keeps running when idle
   task automatic t_dump();
      r0 = dumps;
      p0 = pkts;
      start(1'b0, 1'b0, 16'h0000);
      end_integ();
      await(0, 2000);
      check("dumps", dumps - r0, 32'h0000_0001);
      check("flushes", flushes, 32'h0000_0001);
      await(2, 3000);
      check("pkts", pkts - p0, 0);
      r0 = rgs;
      repeat (100) @(negedge mclk);
      check("rg", rgs - r0, 32'h0000_000a);
   endtask
   initial begin
      rstn = 1'b0;
      frame_start = 1'b0;
      flush_en = 1'b0;
      dual_parallel_split_mode = 1'b0;
      integ_end = 1'b0;
      line_count = 16'h0001;
      dump_line = 16'hffff;
      mismatches = 0;
      compares = 0;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      t_flush_ds();
      t_dps();
      t_dump();
      conclude();
   end
   // Watchdog past the three frames (about 86k cycles) yet under 100k cycles
   initial begin
      #950_000;
      check("run", 0, 1);
      conclude();
   end
endmodule
